// File: hw/limiter_pkg.sv
// Purpose: shared constants and types for the crane overload limiter
// Assumes: 100 MHz sys_clk, 12-bit sensor codes with 5 V full scale
// Notes: register map is word aligned, byte addresses
package limiter_pkg;

  localparam int CLK_HZ = 100_000_000;

  // timing, each figure in its own unit, cycle counts derived
  localparam int DEBOUNCE_MS = 10;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int SENSE_US = 20;
  localparam int SENSE_CYCLES = SENSE_US * (CLK_HZ / 1_000_000);
  localparam int WD_MS = 100;
  localparam int WD_CYCLES = WD_MS * (CLK_HZ / 1000);
  localparam int FLASH_ON_MS = 250;
  localparam int FLASH_ON_CYCLES = FLASH_ON_MS * (CLK_HZ / 1000);
  localparam int FLASH_OFF_MS = 250;
  localparam int FLASH_OFF_CYCLES = FLASH_OFF_MS * (CLK_HZ / 1000);
  localparam int PAUSE_MS = 1000;
  localparam int PAUSE_CYCLES = PAUSE_MS * (CLK_HZ / 1000);

  // sensor range: 0.3 V and 4.5 V at 4096 codes per 5 V
  localparam int ADC_W = 12;
  localparam logic [11:0] ADC_MIN = 12'h0F6;
  localparam logic [11:0] ADC_MAX = 12'hE66;

  // load table: indexed by top angle bits, holds highest safe pressure
  localparam int TABLE_AW = 6;
  localparam logic [11:0] LIMIT_RESET = 12'hE66;

  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_KICK = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_MASK = 8'h0C;
  localparam logic [7:0] REG_ERROR = 8'h10;
  localparam logic [7:0] REG_ANGLE = 8'h14;
  localparam logic [7:0] REG_PRESSURE = 8'h18;
  localparam logic [7:0] REG_TBL_IDX = 8'h1C;
  localparam logic [7:0] REG_TBL_DATA = 8'h20;
  localparam int CTRL_WD_EN = 0;
  localparam logic CTRL_RESET = 1'b0;
  localparam logic [7:0] MASK_RESET = 8'h00;

  // error codes and their bit in the error vector (code k at bit k-1)
  localparam int ERR_BITS = 8;
  localparam int ERR_PRESSURE = 0;
  localparam int ERR_ANGLE = 1;
  localparam int ERR_OVERLOAD = 2;
  localparam int ERR_OUT_FIRST = 3;
  localparam int ERR_HOOK = 7;

  typedef struct packed {
    logic hook;
    logic winchUp;
    logic extOut;
    logic elevDown;
    logic elevUp;
  } switches_t;

  typedef struct packed {
    logic winchUp;
    logic extOut;
    logic elevDown;
    logic elevUp;
  } valves_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } bus_req_t;

  typedef enum logic [1:0] {BLINK_PAUSE, BLINK_ON, BLINK_OFF} blink_state_t;

endpackage

// File: hw/sw_debounce.sv
// Purpose: two-flop synchroniser and stability filter for one pin
// Assumes: pin is asynchronous to sys_clk
// Notes: output moves only after CYCLES equal samples
`timescale 1ns/1ps
module sw_debounce #(
  parameter int CYCLES = 16
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic pinIn,
  output logic clean
);
  localparam int CW = $clog2(CYCLES + 1);
  logic meta_r;
  logic sync_r;
  logic [CW-1:0] cnt_r;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else
    begin
      meta_r <= pinIn;
      sync_r <= meta_r;
    end
  end

  // bounce restarts the count, so a chattering contact never passes
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_r <= '0;
      clean <= 1'b0;
    end
    else if (sync_r == clean)
      cnt_r <= '0;
    else if (cnt_r == CW'(CYCLES - 1))
    begin
      cnt_r <= '0;
      clean <= sync_r;
    end
    else
      cnt_r <= cnt_r + 1'b1;
  end
endmodule

// File: hw/load_table_mem.sv
// Purpose: load table, highest safe pressure per angle step
// Assumes: one write port from software, one read port for the check
// Notes: read data registered; contents reset to a constant limit
`timescale 1ns/1ps
module load_table_mem #(
  parameter int AW = 6,
  parameter int DW = 12,
  parameter logic [DW-1:0] RESET_VAL = '1
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [DW-1:0] wrData,
  input wire logic [AW-1:0] rdAddr,
  output logic [DW-1:0] rdData
);
  logic [DW-1:0] mem_r [2**AW];

  // reset contents so the check never reads an unwritten entry
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < 2**AW; i++)
        mem_r[i] <= RESET_VAL;
    end
    else if (wrEn)
      mem_r[wrAddr] <= wrData;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      rdData <= RESET_VAL;
    else
      rdData <= mem_r[rdAddr];
  end
endmodule

// File: hw/crane_overload_limiter.sv
// Purpose: overload limiting control for a hydraulic crane
// Assumes: sensor codes come from an ADC clocked by sys_clk
// Notes: switches and fault sense pins are asynchronous
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module crane_overload_limiter
  import limiter_pkg::*;
#(
  parameter int DEBOUNCE_CYC = DEBOUNCE_CYCLES,
  parameter int SENSE_CYC = SENSE_CYCLES,
  parameter int WD_CYC = WD_CYCLES,
  parameter int FLASH_ON_CYC = FLASH_ON_CYCLES,
  parameter int FLASH_OFF_CYC = FLASH_OFF_CYCLES,
  parameter int PAUSE_CYC = PAUSE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire bus_req_t busReq,
  output logic [31:0] busRdata,
  input wire switches_t switchIn,
  input wire valves_t faultSense,
  input wire logic supplyLow,
  input wire logic [ADC_W-1:0] angleCode,
  input wire logic [ADC_W-1:0] pressureCode,
  output valves_t valveOut,
  output logic redLed,
  output logic greenLed,
  output logic irq
);

  localparam int NSW = $bits(switches_t);
  localparam int NV = $bits(valves_t);

  switches_t sw;
  valves_t sense;
  logic supplyLowDb;
  logic [ADC_W-1:0] angle_r;
  logic [ADC_W-1:0] pressure_r;
  logic [ADC_W-1:0] limit;
  logic [NV-1:0] fault_r;
  logic [NV-1:0] fault_nxt;
  logic [ERR_BITS-1:0] errVec;
  logic [3:0] lowestCode;
  logic sensorBad;
  logic unsafe;
  logic resetHold;
  logic wdExpire;
  logic [31:0] wdCnt_r;
  logic wdEn_r;
  logic [ERR_BITS-1:0] status_r;
  logic [ERR_BITS-1:0] mask_r;
  logic [TABLE_AW-1:0] tblIdx_r;
  logic tblWr;
  logic kick;
  valves_t valve_nxt;
  blink_state_t blink_r;
  logic [31:0] blinkCnt_r;
  logic [3:0] flashLeft_r;
  logic [3:0] code_r;

  // input conditioning
  genvar g;
  generate
    for (g = 0; g < NSW; g++)
    begin : gSw
      sw_debounce #(.CYCLES(DEBOUNCE_CYC)) uSw (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pinIn(switchIn[g]),
        .clean(sw[g])
      );
    end
    for (g = 0; g < NV; g++)
    begin : gSense
      sw_debounce #(.CYCLES(SENSE_CYC)) uSense (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pinIn(faultSense[g]),
        .clean(sense[g])
      );
    end
  endgenerate

  // short filter on supply sag, long enough to ride out switching noise
  sw_debounce #(.CYCLES(SENSE_CYC)) uSupply (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pinIn(supplyLow),
    .clean(supplyLowDb)
  );

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      angle_r <= '0;
      pressure_r <= '0;
    end
    else
    begin
      angle_r <= angleCode;
      pressure_r <= pressureCode;
    end
  end

  // load table lookup
  assign tblWr = busReq.wr && (busReq.addr == REG_TBL_DATA);

  load_table_mem #(.AW(TABLE_AW), .DW(ADC_W), .RESET_VAL(LIMIT_RESET)) uTable (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .wrEn(tblWr),
    .wrAddr(tblIdx_r),
    .wrData(busReq.wdata[ADC_W-1:0]),
    .rdAddr(angle_r[ADC_W-1 -: TABLE_AW]),
    .rdData(limit)
  );

  // error classification
  always_comb
  begin
    errVec = '0;
    errVec[ERR_PRESSURE] = (pressure_r < ADC_MIN) || (pressure_r > ADC_MAX);
    errVec[ERR_ANGLE] = (angle_r < ADC_MIN) || (angle_r > ADC_MAX);
    errVec[ERR_OVERLOAD] = (pressure_r > limit);
    errVec[ERR_OUT_FIRST +: NV] = fault_r;
    errVec[ERR_HOOK] = ~sw.hook;
  end

  assign sensorBad = errVec[ERR_PRESSURE] | errVec[ERR_ANGLE];
  // a lost sensor makes the table comparison meaningless, so it counts as unsafe
  assign unsafe = sensorBad | errVec[ERR_OVERLOAD];

  // lowest set bit wins
  always_comb
  begin
    lowestCode = 4'h0;
    for (int i = ERR_BITS - 1; i >= 0; i--)
      if (errVec[i])
        lowestCode = 4'(i + 1);
  end

  // watchdog: software must write the kick register while enabled
  assign kick = busReq.wr && (busReq.addr == REG_KICK);
  assign wdExpire = wdEn_r && (wdCnt_r == 32'(WD_CYC - 1));
  assign resetHold = wdExpire | supplyLowDb;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      wdCnt_r <= '0;
    else if (resetHold || kick || !wdEn_r)
      wdCnt_r <= '0;
    else
      wdCnt_r <= wdCnt_r + 32'h0000_0001;
  end

  // output fault latches: held until the switch is released, or cleared by resetHold (watchdog expiry or supply low)
  always_comb
  begin
    for (int i = 0; i < NV; i++)
    begin
      if (sense[i] && valveOut[i])
        fault_nxt[i] = 1'b1;
      else if (!sw[i] && !sense[i])
        fault_nxt[i] = 1'b0;
      else
        fault_nxt[i] = fault_r[i];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      fault_r <= '0;
    else if (resetHold)
      fault_r <= '0;
    else
      fault_r <= fault_nxt;
  end

  // valve drive
  always_comb
  begin
    valve_nxt.elevUp = sw.elevUp;
    valve_nxt.elevDown = sw.elevDown;
    valve_nxt.extOut = sw.extOut & sw.hook;
    valve_nxt.winchUp = sw.winchUp & sw.hook;
    if (unsafe)
      valve_nxt = '0;
    valve_nxt = valve_nxt & ~fault_r & ~fault_nxt;
    if (resetHold)
      valve_nxt = '0;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      valveOut <= '0;
    else
      valveOut <= valve_nxt;
  end

  // indicator sequencer; code latched per pattern so a change never garbles a count
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      blink_r <= BLINK_PAUSE;
      blinkCnt_r <= '0;
      flashLeft_r <= '0;
      code_r <= '0;
    end
    else if (resetHold)
    begin
      blink_r <= BLINK_PAUSE;
      blinkCnt_r <= '0;
      flashLeft_r <= '0;
      code_r <= '0;
    end
    else
    begin
      unique case (blink_r)
        BLINK_PAUSE:
        begin
          if (blinkCnt_r == 32'(PAUSE_CYC - 1))
          begin
            blinkCnt_r <= '0;
            code_r <= lowestCode;
            flashLeft_r <= (lowestCode == 4'h0) ? 4'h1 : lowestCode;
            blink_r <= BLINK_ON;
          end
          else
            blinkCnt_r <= blinkCnt_r + 32'h0000_0001;
        end
        BLINK_ON:
        begin
          if (blinkCnt_r == 32'(FLASH_ON_CYC - 1))
          begin
            blinkCnt_r <= '0;
            blink_r <= BLINK_OFF;
          end
          else
            blinkCnt_r <= blinkCnt_r + 32'h0000_0001;
        end
        BLINK_OFF:
        begin
          if (blinkCnt_r == 32'(FLASH_OFF_CYC - 1))
          begin
            blinkCnt_r <= '0;
            flashLeft_r <= flashLeft_r - 4'h1;
            blink_r <= (flashLeft_r == 4'h1) ? BLINK_PAUSE : BLINK_ON;
          end
          else
            blinkCnt_r <= blinkCnt_r + 32'h0000_0001;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      redLed <= 1'b0;
      greenLed <= 1'b0;
    end
    else
    begin
      redLed <= (blink_r == BLINK_ON) && (code_r != 4'h0);
      greenLed <= (blink_r == BLINK_ON) && (code_r == 4'h0);
    end
  end

  // software registers
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wdEn_r <= CTRL_RESET;
      mask_r <= MASK_RESET;
      tblIdx_r <= '0;
    end
    else if (resetHold)
      wdEn_r <= CTRL_RESET;
    else if (busReq.wr)
    begin
      unique case (busReq.addr)
        REG_CTRL: wdEn_r <= busReq.wdata[CTRL_WD_EN];
        REG_MASK: mask_r <= busReq.wdata[ERR_BITS-1:0];
        REG_TBL_IDX: tblIdx_r <= busReq.wdata[TABLE_AW-1:0];
        default:
        begin
        end
      endcase
    end
  end

  // sticky status, write one to clear; a present condition re-sets at once
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      status_r <= '0;
    else if (busReq.wr && (busReq.addr == REG_STATUS))
      status_r <= (status_r & ~busReq.wdata[ERR_BITS-1:0]) | errVec;
    else
      status_r <= status_r | errVec;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      irq <= 1'b0;
    else
      irq <= |(status_r & mask_r);
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      busRdata <= '0;
    else if (busReq.rd)
    begin
      unique case (busReq.addr)
        REG_CTRL: busRdata <= {31'h0000_0000, wdEn_r};
        REG_STATUS: busRdata <= {24'h00_0000, status_r};
        REG_MASK: busRdata <= {24'h00_0000, mask_r};
        REG_ERROR: busRdata <= {12'h000, 4'(NV), valveOut, lowestCode, errVec};
        REG_ANGLE: busRdata <= {20'h0_0000, angle_r};
        REG_PRESSURE: busRdata <= {20'h0_0000, pressure_r};
        REG_TBL_IDX: busRdata <= {26'h000_0000, tblIdx_r};
        default: busRdata <= '0;
      endcase
    end
    else
      busRdata <= '0;
  end

endmodule

// File: bench/limiter_sva.sv
// Purpose: port checker for the overload limiter
// Assumes: short sim timing, sensors held over each window
// Notes: windows are loose since debounce hides exact edges
`timescale 1ns/1ps
module limiter_sva
  import limiter_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire bus_req_t busReq,
  input wire logic [31:0] busRdata,
  input wire switches_t switchIn,
  input wire valves_t faultSense,
  input wire logic supplyLow,
  input wire logic [ADC_W-1:0] angleCode,
  input wire logic [ADC_W-1:0] pressureCode,
  input wire valves_t valveOut,
  input wire logic redLed,
  input wire logic greenLed,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  function automatic logic [3:0] low_code(input logic [7:0] v);
    low_code = 4'h0;
    for (int k = 7; k >= 0; k--)
      if (v[k])
        low_code = 4'(k + 1);
  endfunction

  press_range_a: assert property ((pressureCode < ADC_MIN || pressureCode > ADC_MAX)[*4] |-> valveOut == '0)
    else $error("valves on, pressure out of range");
  angle_range_a: assert property ((angleCode < ADC_MIN || angleCode > ADC_MAX)[*4] |-> valveOut == '0)
    else $error("valves on, angle out of range");
  hook_open_a: assert property ((!switchIn.hook)[*8] ##1 (!switchIn.hook)[*4] |-> !valveOut.winchUp && !valveOut.extOut)
    else $error("winch or extension on, hook open");
  supply_low_a: assert property (supplyLow[*8] |-> valveOut == '0)
    else $error("valves on, supply low");
  short_off_a: assert property (faultSense.elevUp |-> ##[1:10] !valveOut.elevUp)
    else $error("shorted output kept on");
  follow_on_a: assert property ($rose(valveOut.elevUp) |-> $past(switchIn.elevUp, 4))
    else $error("valve on without its switch");
  led_excl_a: assert property (!(redLed && greenLed))
    else $error("both indicators lit");
  low_code_a: assert property ($past(busReq.rd) && $past(busReq.addr) == REG_ERROR |->
    busRdata[11:8] == low_code(busRdata[7:0]))
    else $error("shown code is not the lowest");
endmodule

bind crane_overload_limiter limiter_sva i_sva (.sys_clk, .rst_b, .busReq, .busRdata, .switchIn, .faultSense,
  .supplyLow, .angleCode, .pressureCode, .valveOut, .redLed, .greenLed, .irq);

// File: bench/coil_load_model.sv
// Purpose: valve coils, any of which can be shorted
// Assumes: overcurrent shows only while a coil is driven
// Notes: no sense delay; the limiter filters its own input
`timescale 1ns/1ps
module coil_load_model
  import limiter_pkg::*;
(
  input wire valves_t valveOut,
  input wire valves_t shortMask,
  output valves_t faultSense
);
  assign faultSense = valveOut & shortMask;
endmodule

// File: bench/crane_overload_limiter_bench.sv
// Purpose: scenario bench for the overload limiter
// Assumes: shortened timing parameters, one clock
// Notes: flashes are counted between two long pauses
`timescale 1ns/1ps
module crane_overload_limiter_bench
  import limiter_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_b;
  bus_req_t busReq;
  logic [31:0] busRdata;
  switches_t switchIn;
  valves_t faultSense;
  valves_t valveOut;
  valves_t shortMask;
  logic supplyLow;
  logic [11:0] angleCode;
  logic [11:0] pressureCode;
  logic redLed;
  logic greenLed;
  logic irq;
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [31:0] rd;

  always #5 sys_clk = ~sys_clk;

  crane_overload_limiter #(.DEBOUNCE_CYC(4), .SENSE_CYC(3), .WD_CYC(50), .FLASH_ON_CYC(5), .FLASH_OFF_CYC(5),
    .PAUSE_CYC(12)) i_dut (.sys_clk, .rst_b, .busReq, .busRdata, .switchIn, .faultSense, .supplyLow,
    .angleCode, .pressureCode, .valveOut, .redLed, .greenLed, .irq);
  coil_load_model i_coil (.valveOut, .shortMask, .faultSense);

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // run takes under 1000 cycles
  always @(posedge sys_clk)
    if (++cycles == 8000)
    begin
      bad_count++;
      finish_test();
    end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk) busReq <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk) busReq <= '0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF);
    @(posedge sys_clk) busReq <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge sys_clk) busReq <= '0;
    #1 chk(busRdata & m, e);
  endtask

  // hold mode waits the full 15 cycles before its one check, not just until the level arrives
  task automatic wait_valves(input valves_t exp, input bit hold = 1'b0);
    repeat (hold ? 15 : 40)
      if (hold || valveOut !== exp)
        @(posedge sys_clk) #1;
    chk(valveOut, exp);
  endtask

  task automatic flash_chk(input bit red, input int exp);
    int n = 0;
    int quiet = 0;
    logic prev = 1'b0;
    // both dark for 10 cycles only inside a pause, so counting starts on a pattern boundary
    for (int i = 0; i < 200 && quiet < 10; i++)
      @(posedge sys_clk) #1 quiet = (redLed || greenLed) ? 0 : quiet + 1;
    quiet = 0;
    for (int i = 0; i < 200 && quiet < 10; i++)
    begin
      @(posedge sys_clk) #1;
      n += ((red ? redLed : greenLed) === 1'b1 && !prev);
      prev = red ? redLed : greenLed;
      quiet = (redLed || greenLed) ? 0 : quiet + 1;
    end
    chk(n, exp);
  endtask

  task automatic t_follow();
    @(posedge sys_clk) switchIn <= 5'h1F;
    wait_valves(4'hF);
    @(posedge sys_clk) switchIn <= 5'h1E;
    wait_valves(4'hE);
    @(posedge sys_clk) switchIn <= 5'h1F;
    repeat (2) @(posedge sys_clk);
    switchIn <= 5'h1E;
    wait_valves(4'hE, 1'b1);
    @(posedge sys_clk) switchIn <= 5'h0F;
    wait_valves(4'h3);
    rchk(REG_ERROR, 32'h0004_3880);
    @(posedge sys_clk) switchIn <= 5'h1F;
    wait_valves(4'hF);
  endtask

  task automatic t_sensor();
    logic [11:0] p [4] = '{12'h0F5, 12'hE67, 12'h400, 12'h0F6};
    logic [11:0] a [4] = '{12'h800, 12'h800, 12'hE67, 12'hE66};
    logic [7:0] s [4] = '{8'h01, 8'h05, 8'h02, 8'h00};
    for (int i = 0; i < 4; i++)
    begin
      bus_wr(REG_STATUS, 8'hFF);
      @(posedge sys_clk) pressureCode <= p[i];
      angleCode <= a[i];
      wait_valves(s[i] ? 4'h0 : 4'hF, s[i] == 0);
      rchk(REG_STATUS, s[i]);
      @(posedge sys_clk) pressureCode <= 12'h400;
      angleCode <= 12'h800;
      wait_valves(4'hF);
    end
  endtask

  task automatic t_overload();
    bus_wr(REG_TBL_IDX, 8'h20);
    rchk(REG_TBL_IDX, 8'h20);
    bus_wr(REG_TBL_DATA, 12'h3FF);
    wait_valves(4'h0);
    bus_wr(REG_STATUS, 8'hFF);
    rchk(REG_STATUS, 8'h04);
    chk(irq, 1'b0);
    bus_wr(REG_MASK, 8'h04);
    rchk(REG_MASK, 8'h04);
    chk(irq, 1'b1);
    @(posedge sys_clk) pressureCode <= 12'h3FF;
    wait_valves(4'hF, 1'b1);
    rchk(REG_PRESSURE, 12'h3FF);
    rchk(REG_ANGLE, 12'h800);
    chk(irq, 1'b1);
    bus_wr(REG_STATUS, 8'h04);
    rchk(REG_STATUS, 8'h00);
    chk(irq, 1'b0);
    bus_wr(REG_MASK, 8'h00);
    bus_wr(REG_TBL_DATA, 12'hE66);
    @(posedge sys_clk) pressureCode <= 12'h400;
  endtask

  task automatic t_short();
    @(posedge sys_clk) shortMask <= 4'h9;
    wait_valves(4'h6);
    @(posedge sys_clk) switchIn <= 5'h0F;
    wait_valves(4'h2);
    rchk(REG_ERROR, 32'h0004_24C8);
    flash_chk(1'b1, 4);
    @(posedge sys_clk) shortMask <= 4'h0;
    switchIn <= 5'h10;
    flash_chk(1'b0, 1);
    flash_chk(1'b1, 0);
    @(posedge sys_clk) switchIn <= 5'h1F;
    wait_valves(4'hF);
  endtask

  task automatic t_power();
    bit dropped = 1'b0;
    @(posedge sys_clk) supplyLow <= 1'b1;
    wait_valves(4'h0);
    @(posedge sys_clk) supplyLow <= 1'b0;
    wait_valves(4'hF);
    bus_wr(REG_CTRL, 1'b1);
    repeat (3)
    begin
      repeat (30) @(posedge sys_clk);
      bus_wr(REG_KICK, 1'b0);
    end
    rchk(REG_CTRL, 1'b1);
    repeat (60)
      @(posedge sys_clk) #1 dropped |= (valveOut === 4'h0);
    chk(dropped, 1'b1);
    rchk(REG_CTRL, 1'b0);
  endtask

  initial
  begin
    rst_b <= 1'b0;
    busReq <= '0;
    switchIn <= '0;
    shortMask <= '0;
    supplyLow <= 1'b0;
    angleCode <= 12'h800;
    pressureCode <= 12'h400;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    rchk(REG_CTRL, 1'b0);
    rchk(REG_MASK, 8'h00);
    rchk(8'h40, 1'b0);
    rchk(REG_KICK, 1'b0);
    t_follow();
    t_sensor();
    t_overload();
    t_short();
    t_power();
    finish_test();
  end
endmodule
